// ==== abc_asserts.sv ====
/* Checker for the host-device link: power sequencing, busy and handshakes.
   Assumes one clock with a synchronous active-high reset. */
`timescale 1ns/1ps
module abc_asserts import abc_pkg::*; (
    input wire logic        I_CLK,
    input wire logic        I_RST,
    input wire logic        wr_valid,
    input wire logic        wr_ready,
    input wire logic [7:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic        rd_valid,
    input wire logic        rd_ack,
    input wire logic        busy
);
    logic [1:0] pd, next_pd;
    // Power state from shutdown writes: 0 deep, 1 waking, 2 active
    wire        shut = wr_valid && wr_ready && addr == REG_SHUTDOWN;
    wire        cal = wr_valid && wr_ready && addr == REG_CAL_CTRL && pd == 2'h2;
    assign next_pd = !shut ? pd : pd == 2'h0 ? {1'b0, !wdata[DEEP_PD_BIT]} : pd == 2'h1 ?
                     {wdata[BLOCK_EN_BIT], !wdata[BLOCK_EN_BIT]} : {!wdata[DEEP_PD_BIT], 1'b0};
    always_ff @(posedge I_CLK) pd <= I_RST ? 2'h0 : next_pd;
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    // Each check ties a link signal to the write, read, reset or power state that causes it
    chk_reset_idle: assert property ($fell(I_RST) |-> !busy && !wr_valid && !rd_valid)
        else $error("link active after reset");
    chk_deep_idle: assert property (pd == 2'h0 |-> !busy)
        else $error("busy in deep power-down");
    chk_wake_idle: assert property (pd == 2'h1 |-> !busy)
        else $error("busy before blocks enabled");
    chk_cal_span: assert property (cal && wdata[2:0] == 3'b010 |-> ##[1:3] busy ##[1:80] !busy)
        else $error("calibration busy window wrong");
    chk_track_start: assert property (cal && wdata[2:0] == 3'b111 |-> ##[1:3] busy)
        else $error("tracking did not start");
    chk_write_once: assert property (wr_valid && wr_ready |=> !wr_valid)
        else $error("link write repeated");
    chk_read_ack: assert property (rd_valid |-> rd_ack && !wr_valid)
        else $error("link read not acknowledged");
    chk_read_once: assert property (rd_valid |=> !rd_valid)
        else $error("link read repeated");
    cover property (pd == 2'h2);
    cover property (cal && wdata[2:0] == 3'b111);
    cover property (rd_valid && rd_ack);
endmodule : abc_asserts

// ==== abc_device.sv ====
/*
 Device end: power-up sequencing, offset calibration, temperature tracking with table
 interpolation, DAC code generation and alarm. Assumes ADC and analog loop outside;
 inputs synchronous to I_CLK.
*/
// Implementation choices: the address map and the AXI4-Lite register port.
// Operation
// RULE1: Power-up lands in deepest power-down, blocks off
// RULE2: Two shutdown writes: clear deep bit, then enable
// RULE3: Follow 0, run 1 triggers one-time calibration
// RULE4: Offset correction spans zero to 24 mV
// RULE5: Follow, run, schedule all set starts tracking
// RULE6: Each request measures temperature, compares with previous
// RULE7: Changed temperature refetches tables, rewrites gate DAC
// RULE8: Linear interpolation between bracketing table entries
// RULE9: Changed aux factor tables trigger DAC correction
// RULE10: Host loads setpoint and tables after power-up
// RULE11: Class AB tables set gate code directly
// RULE12: Converter results are 12-bit
// RULE13: Alarm on over-temperature, sense or gate excess
// RULE14: Modes 01/11: low start input begins conversion
// RULE15: Unchanged temperature and tables leave DAC alone
`timescale 1ns/1ps
module abc_device
    import abc_pkg::*;
#(
    parameter bit CLASS_AB     = 1'b0,
    parameter int MEAS_PERIOD  = MEAS_PERIOD_CYC
) (
    input  wire logic              I_CLK,
    input  wire logic              I_RST,
    abc_link_if.device             link,
    input  wire logic              I_OFS_POSITIVE,
    input  wire logic              I_ADC_VALID,
    input  wire logic [11:0]       I_ADC_DATA,
    input  wire logic [11:0]       I_SENSE_CODE,
    input  wire logic [11:0]       I_GATE_CODE,
    output logic                   O_BLOCKS_ON,
    output logic                   O_ADC_REQ,
    output logic                   O_ADC_CHAN,
    output logic [11:0]            O_DAC1,
    output logic [11:0]            O_DAC2,
    output logic [5:0]             O_OFS_CODE
);
    abc_pd_type  pd_state;
    abc_seq_type seq;
    logic [2:0]  cal_ctrl;
    logic [1:0]  clk_mode;
    logic [11:0] setpoint;
    logic [11:0] lut [2][8];
    logic [11:0] aux [2];
    logic [11:0] prev_temp [2];
    logic [1:0]  aux_dirty;
    logic [11:0] temp_limit, sense_limit, gate_limit, meas;
    logic [31:0] timer;
    logic        start_n_q, chan, alarm_q;
    logic [15:0] rdata;

    // Saturating add of two unsigned codes
    function automatic logic [11:0] sat_add(input logic [11:0] a, input logic [11:0] b);
        logic [12:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[12] ? CODE_MAX : s[11:0];
    endfunction : sat_add

    // Straight-line estimate between two entries, clamped to the code range
    function automatic logic [11:0] interp(input logic [11:0] lo, input logic [11:0] hi,
                                           input logic [8:0] frac);
        logic signed [13:0] diff;
        logic signed [23:0] prod;
        logic signed [15:0] sum;
        diff = $signed({2'b00, hi}) - $signed({2'b00, lo});
        prod = diff * $signed({1'b0, frac});
        sum  = $signed({4'b0000, lo}) + $signed(prod[23:9]);
        if (sum < 0) return CODE_ZERO;
        else if (sum > $signed({4'b0000, CODE_MAX})) return CODE_MAX;
        else return sum[11:0];
    endfunction : interp

    // Link decode
    wire        wr       = link.wr_valid && link.wr_ready;
    wire        wr_shut  = wr && link.addr == REG_SHUTDOWN;
    wire        wr_cal   = wr && link.addr == REG_CAL_CTRL;
    wire        active   = pd_state == PD_ACTIVE;
    wire        tracking = active && (&cal_ctrl);                          // RULE5
    wire        one_cal  = wr_cal && !link.wdata[FOLLOW_BIT]
                           && link.wdata[RUN_CAL_BIT];                      // RULE3
    wire        ext_mode = clk_mode == CLK_MODE_EXT_A || clk_mode == CLK_MODE_EXT_B;
    wire        ext_go   = ext_mode && start_n_q && !link.conversion_start_n; // RULE14
    wire        tick     = tracking && timer == 32'(MEAS_PERIOD - 1);
    wire        meas_go  = active && (tick || ext_go);
    wire        tbl_ch   = link.wdata[TBL_CH_BIT];
    wire [2:0]  tbl_idx  = link.wdata[TBL_IDX_LSB +: LUT_IDX_W];
    // Offset-binary view of the signed temperature picks the segment
    wire [11:0] t_ub     = {~meas[11], meas[10:0]};
    wire [2:0]  seg      = t_ub[11:FRAC_W];
    wire [2:0]  seg_hi   = (seg == 3'h7) ? seg : seg + 3'h1;
    wire [11:0] corr     = interp(lut[chan][seg], lut[chan][seg_hi], t_ub[FRAC_W-1:0]); // RULE8
    wire [11:0] base     = CLASS_AB ? corr : sat_add(setpoint, corr);       // RULE11
    wire [11:0] new_code = sat_add(base, aux[chan]);
    wire        changed  = meas != prev_temp[chan];                         // RULE6
    wire        over_t   = $signed(I_ADC_DATA) > $signed(temp_limit);

    assign link.wr_ready = 1'b1;
    assign link.rd_ack   = link.rd_valid;
    assign link.rdata    = rdata;
    assign link.alarm    = alarm_q;
    assign link.busy     = seq != SQ_IDLE;
    assign O_BLOCKS_ON   = active;
    assign O_ADC_CHAN    = chan;

    // Power-down sequencer: first write must clear the deep bit, second enables
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            pd_state <= PD_DEEP;                                            // RULE1
        end else if (wr_shut) begin
            case (pd_state)
                PD_DEEP:   pd_state <= link.wdata[DEEP_PD_BIT] ? PD_DEEP : PD_WAKE; // RULE2
                PD_WAKE:   pd_state <= link.wdata[BLOCK_EN_BIT] ? PD_ACTIVE : PD_WAKE; // RULE2
                default:   pd_state <= link.wdata[DEEP_PD_BIT] ? PD_DEEP : PD_ACTIVE;
            endcase
        end
    end

    // Configuration and table storage; an aux table write marks its channel dirty
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            cal_ctrl    <= 3'h0;
            clk_mode    <= CLK_MODE_RESET;
            setpoint    <= CODE_ZERO;
            aux         <= '{default: CODE_ZERO};
            lut         <= '{default: '{default: CODE_ZERO}};
            temp_limit  <= CODE_MAX >> 1;   // Largest positive signed code, limit is signed
            sense_limit <= CODE_MAX;
            gate_limit  <= CODE_MAX;
        end else if (wr) begin
            if (link.addr == REG_CAL_CTRL) cal_ctrl <= link.wdata[2:0];
            else if (link.addr == REG_CLK_MODE) clk_mode <= link.wdata[1:0];
            else if (link.addr == REG_SETPOINT) setpoint <= link.wdata[11:0];
            else if (link.addr == REG_LUT) lut[tbl_ch][tbl_idx] <= link.wdata[11:0];
            else if (link.addr == REG_AUX_TABLE) aux[tbl_ch] <= link.wdata[11:0];
            else if (link.addr == REG_TEMP_LIMIT) temp_limit <= link.wdata[11:0];
            else if (link.addr == REG_SENSE_LIMIT) sense_limit <= link.wdata[11:0];
            else if (link.addr == REG_GATE_LIMIT) gate_limit <= link.wdata[11:0];
        end
    end

    // Interval timer runs only while tracking, so the first request comes a full period in
    always_ff @(posedge I_CLK) begin
        if (I_RST || !tracking || tick) timer <= 32'h0;
        else timer <= timer + 32'h1;
    end

    // Sequencer: calibration, measurement and DAC update
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            seq        <= SQ_IDLE;
            O_ADC_REQ  <= 1'b0;
            chan       <= 1'b0;
            meas       <= CODE_ZERO;
            prev_temp  <= '{default: CODE_ZERO};
            O_DAC1     <= CODE_ZERO;
            O_DAC2     <= CODE_ZERO;
            O_OFS_CODE <= '0;
            aux_dirty  <= 2'b00;
            start_n_q  <= 1'b1;
        end else begin
            start_n_q <= link.conversion_start_n;
            O_ADC_REQ <= 1'b0;
            // Set wins: a table write in the same cycle as the clear keeps the mark
            if (wr && link.addr == REG_AUX_TABLE) aux_dirty[tbl_ch] <= 1'b1;
            else if (seq == SQ_WRITE && tracking) aux_dirty[chan] <= 1'b0;
            if (!tracking && wr && link.addr == REG_DIRECT_DAC1) O_DAC1 <= link.wdata[11:0];
            if (!tracking && wr && link.addr == REG_DIRECT_DAC2) O_DAC2 <= link.wdata[11:0];
            case (seq)
                SQ_IDLE: begin
                    if (active && (one_cal || (wr_cal && &link.wdata[2:0]))) begin
                        O_OFS_CODE <= '0;
                        seq        <= SQ_CAL;
                    end else if (meas_go) begin
                        O_ADC_REQ <= 1'b1;
                        seq       <= SQ_MEAS;
                    end else if (tracking && aux_dirty[chan]) begin
                        seq <= SQ_CALC;                                     // RULE9
                    end
                end
                SQ_CAL: begin
                    // Step the trim up until the residual offset reaches zero or the code reaches OFS_MAX
                    if (I_OFS_POSITIVE && O_OFS_CODE != OFS_MAX) O_OFS_CODE <= O_OFS_CODE + 6'h1; // RULE4
                    else seq <= SQ_IDLE;
                end
                SQ_MEAS: begin
                    if (I_ADC_VALID) begin
                        meas <= I_ADC_DATA;                                 // RULE12
                        seq  <= SQ_CALC;
                    end
                end
                SQ_CALC: begin
                    // Nothing moved: keep the code and move to the other channel
                    if (tracking && (changed || aux_dirty[chan])) seq <= SQ_WRITE; // RULE7
                    else begin
                        prev_temp[chan] <= meas;
                        chan            <= ~chan;
                        seq             <= SQ_IDLE;                         // RULE15
                    end
                end
                default: begin
                    if (chan) O_DAC2 <= new_code;                           // RULE7
                    else O_DAC1 <= new_code;
                    prev_temp[chan] <= meas;
                    chan            <= ~chan;
                    seq             <= SQ_IDLE;
                end
            endcase
        end
    end

    // Alarm is a level held while active and the sense or gate limit is exceeded; over-temperature counts only on a converter result
    always_ff @(posedge I_CLK) begin
        if (I_RST) alarm_q <= 1'b0;
        else alarm_q <= active && ((I_ADC_VALID && over_t) || I_SENSE_CODE > sense_limit
                                   || I_GATE_CODE > gate_limit);           // RULE13
    end

    // Readback registered one cycle after the read strobe is seen
    always_ff @(posedge I_CLK) begin
        if (I_RST) rdata <= 16'h0000;
        else if (link.rd_valid) begin
            if (link.addr == REG_STATUS)
                rdata <= {8'h00, seq != SQ_IDLE, alarm_q, tracking, 2'b00, pd_state};
            else if (link.addr == REG_LAST_TEMP) rdata <= {4'h0, meas};
            else if (link.addr == REG_DAC1_RB) rdata <= {4'h0, O_DAC1};
            else if (link.addr == REG_DAC2_RB) rdata <= {4'h0, O_DAC2};
            else if (link.addr == REG_OFFSET_RB) rdata <= {10'h000, O_OFS_CODE};
            else rdata <= 16'h0000;
        end
    end
endmodule : abc_device

// ==== abc_host.sv ====
/*
 Host end: AXI4-Lite slave for software, master of the device register link.
 Assumes software orders the power-up, table load and calibration writes.
*/
`timescale 1ns/1ps
module abc_host
    import abc_pkg::*;
(
    input  wire logic        I_CLK,
    input  wire logic        I_RST,
    abc_link_if.host         link,
    input  wire logic [7:0]  I_AWADDR,
    input  wire logic        I_AWVALID,
    output logic             O_AWREADY,
    input  wire logic [31:0] I_WDATA,
    input  wire logic [3:0]  I_WSTRB,
    input  wire logic        I_WVALID,
    output logic             O_WREADY,
    output logic [1:0]       O_BRESP,
    output logic             O_BVALID,
    input  wire logic        I_BREADY,
    input  wire logic [7:0]  I_ARADDR,
    input  wire logic        I_ARVALID,
    output logic             O_ARREADY,
    output logic [31:0]      O_RDATA,
    output logic [1:0]       O_RRESP,
    output logic             O_RVALID,
    input  wire logic        I_RREADY,
    output logic             O_IRQ
);
    logic        aw_held, w_held, wr_pend, rd_pend, alarm_q, start_req, rd_take;
    logic [7:0]  aw_addr, l_addr;
    logic [31:0] w_data;
    logic [15:0] l_data, rd_word;
    logic [2:0]  irq_stat, irq_mask;

    wire do_wr    = aw_held && w_held && !O_BVALID;
    wire wr_map   = aw_addr == AX_CMD_WRITE || aw_addr == AX_CMD_READ
                    || aw_addr == AX_IRQ_STATUS || aw_addr == AX_IRQ_MASK || aw_addr == AX_CTRL;
    wire idle     = !wr_pend && !rd_pend;
    wire post_wr  = do_wr && aw_addr == AX_CMD_WRITE && idle;
    wire post_rd  = do_wr && aw_addr == AX_CMD_READ && idle;
    wire wr_done  = wr_pend && link.wr_ready;
    wire rd_done  = rd_pend && link.rd_ack;
    wire [2:0] ev = {alarm_q == 1'b0 && link.alarm, rd_done, wr_done};

    // Handshake outputs
    assign O_AWREADY = !aw_held;
    assign O_WREADY  = !w_held;
    assign O_ARREADY = !O_RVALID;
    assign O_IRQ     = |(irq_stat & irq_mask);
    // Host holds start high unless software asks for a pin-started conversion
    assign link.conversion_start_n = !start_req;                            // RULE14
    assign link.wr_valid = wr_pend;                                         // RULE2
    assign link.rd_valid = rd_pend;
    assign link.addr     = l_addr;
    assign link.wdata    = l_data;

    // Address and data captured in either order
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            aw_held  <= 1'b0;
            w_held   <= 1'b0;
            aw_addr  <= 8'h00;
            w_data   <= 32'h0;
            O_BVALID <= 1'b0;
            O_BRESP  <= RESP_OKAY;
        end else begin
            if (I_AWVALID && !aw_held) begin
                aw_held <= 1'b1;
                aw_addr <= I_AWADDR;
            end
            if (I_WVALID && !w_held) begin
                w_held <= 1'b1;
                w_data <= I_WDATA;
            end
            if (do_wr) begin
                aw_held  <= 1'b0;
                w_held   <= 1'b0;
                O_BVALID <= 1'b1;
                O_BRESP  <= wr_map ? RESP_OKAY : RESP_SLVERR;
            end else if (I_BREADY) O_BVALID <= 1'b0;
        end
    end

    // Link master: one transfer outstanding; commands while busy are dropped
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            wr_pend   <= 1'b0;
            rd_pend   <= 1'b0;
            l_addr    <= 8'h00;
            l_data    <= 16'h0000;
            rd_word   <= 16'h0000;
            irq_stat  <= 3'h0;
            irq_mask  <= 3'h0;
            start_req <= 1'b0;
            rd_take   <= 1'b0;
            alarm_q   <= 1'b0;
        end else begin
            alarm_q <= link.alarm;
            if (post_wr) begin
                wr_pend <= 1'b1;                                            // RULE10
                l_addr  <= w_data[16+:8];
                l_data  <= w_data[15:0];                                    // RULE3 RULE5
            end else if (wr_done) wr_pend <= 1'b0;
            if (post_rd) begin
                rd_pend <= 1'b1;
                l_addr  <= w_data[7:0];
            end else if (rd_done) rd_pend <= 1'b0;
            rd_take <= rd_done;     // Readback is registered one edge after the acknowledge edge
            if (rd_take) rd_word <= link.rdata;
            if (do_wr && aw_addr == AX_IRQ_MASK && I_WSTRB[0]) irq_mask <= w_data[2:0];
            if (do_wr && aw_addr == AX_CTRL && I_WSTRB[0]) start_req <= w_data[0];
            // New events win over a same-cycle write-one-to-clear
            if (do_wr && aw_addr == AX_IRQ_STATUS) irq_stat <= (irq_stat & ~w_data[2:0]) | ev;
            else irq_stat <= irq_stat | ev;
        end
    end

    // Read channel, answer one cycle after the address is taken
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            O_RVALID <= 1'b0;
            O_RDATA  <= 32'h0;
            O_RRESP  <= RESP_OKAY;
        end else if (I_ARVALID && !O_RVALID) begin
            O_RVALID <= 1'b1;
            O_RRESP  <= RESP_OKAY;
            if (I_ARADDR == AX_RDATA) O_RDATA <= {16'h0000, rd_word};
            else if (I_ARADDR == AX_STATUS)
                O_RDATA <= {28'h0, link.busy, link.alarm, rd_pend, wr_pend};
            else if (I_ARADDR == AX_IRQ_STATUS) O_RDATA <= {29'h0, irq_stat};
            else if (I_ARADDR == AX_IRQ_MASK) O_RDATA <= {29'h0, irq_mask};
            else if (I_ARADDR == AX_CTRL) O_RDATA <= {31'h0, start_req};
            else begin
                O_RDATA <= 32'h0;
                O_RRESP <= RESP_SLVERR;
            end
        end else if (I_RREADY) O_RVALID <= 1'b0;
    end
endmodule : abc_host

// ==== abc_link_if.sv ====
/*
 Register link between host end and device end, framing abstracted to word transfers.
 Assumes both ends share I_CLK; the testbench instantiates and connects it.
*/
`timescale 1ns/1ps
interface abc_link_if;
    logic        wr_valid;
    logic        wr_ready;
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        rd_valid;
    logic        rd_ack;
    logic [15:0] rdata;
    logic        conversion_start_n;
    logic        alarm;
    logic        busy;

    modport host (output wr_valid, output addr, output wdata, output rd_valid,
                  output conversion_start_n, input wr_ready, input rd_ack,
                  input rdata, input alarm, input busy);
    modport device (input wr_valid, input addr, input wdata, input rd_valid,
                    input conversion_start_n, output wr_ready, output rd_ack,
                    output rdata, output alarm, output busy);
endinterface : abc_link_if

// ==== abc_pkg.sv ====
/*
 Shared constants for the bias-control sequencer: link register map, field positions,
 power and sequencer states, table geometry and timing. Assumes one 250 MHz clock.
*/
package abc_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 16;
    localparam int          CODE_W          = 12;
    // Link register map, written by the host
    localparam logic [7:0]  REG_SHUTDOWN    = 8'h00;
    localparam logic [7:0]  REG_CAL_CTRL    = 8'h01;
    localparam logic [7:0]  REG_CLK_MODE    = 8'h02;
    localparam logic [7:0]  REG_SETPOINT    = 8'h03;
    localparam logic [7:0]  REG_DIRECT_DAC1 = 8'h04;
    localparam logic [7:0]  REG_DIRECT_DAC2 = 8'h05;
    localparam logic [7:0]  REG_LUT         = 8'h06;
    localparam logic [7:0]  REG_AUX_TABLE   = 8'h07;
    localparam logic [7:0]  REG_TEMP_LIMIT  = 8'h08;
    localparam logic [7:0]  REG_SENSE_LIMIT = 8'h09;
    localparam logic [7:0]  REG_GATE_LIMIT  = 8'h0A;
    // Link register map, read by the host
    localparam logic [7:0]  REG_STATUS      = 8'h10;
    localparam logic [7:0]  REG_LAST_TEMP   = 8'h11;
    localparam logic [7:0]  REG_DAC1_RB     = 8'h12;
    localparam logic [7:0]  REG_DAC2_RB     = 8'h13;
    localparam logic [7:0]  REG_OFFSET_RB   = 8'h14;
    // Field positions
    localparam int          DEEP_PD_BIT     = 0;
    localparam int          BLOCK_EN_BIT    = 1;
    localparam int          FOLLOW_BIT      = 0;
    localparam int          RUN_CAL_BIT     = 1;
    localparam int          SCHED_BIT       = 2;
    localparam int          TBL_CH_BIT      = 15;
    localparam int          TBL_IDX_LSB     = 12;
    localparam logic [1:0]  CLK_MODE_EXT_A  = 2'b01;
    localparam logic [1:0]  CLK_MODE_EXT_B  = 2'b11;
    localparam logic [1:0]  CLK_MODE_RESET  = 2'b00;
    // Table geometry: 8 segments over the 12-bit temperature span
    localparam int          LUT_IDX_W       = 3;
    localparam int          FRAC_W          = CODE_W - LUT_IDX_W;
    localparam logic [11:0] CODE_MAX        = 12'hFFF;
    localparam logic [11:0] CODE_ZERO       = 12'h000;
    // Offset correction span 0..24 mV in 375 uV steps
    localparam int          OFS_SPAN_UV     = 24000;
    localparam int          OFS_STEP_UV     = 375;
    localparam int          OFS_W           = 6;
    localparam logic [5:0]  OFS_MAX         = 6'(OFS_SPAN_UV / OFS_STEP_UV - 1);
    // Autonomous measurement interval
    localparam int          CLK_MHZ         = 250;
    localparam int          MEAS_PERIOD_US  = 1000;
    localparam int          MEAS_PERIOD_CYC = MEAS_PERIOD_US * CLK_MHZ;
    // Host AXI4-Lite map (byte addresses)
    localparam logic [7:0]  AX_CMD_WRITE    = 8'h00;
    localparam logic [7:0]  AX_CMD_READ     = 8'h04;
    localparam logic [7:0]  AX_RDATA        = 8'h08;
    localparam logic [7:0]  AX_STATUS       = 8'h0C;
    localparam logic [7:0]  AX_IRQ_STATUS   = 8'h10;
    localparam logic [7:0]  AX_IRQ_MASK     = 8'h14;
    localparam logic [7:0]  AX_CTRL         = 8'h18;
    localparam logic [1:0]  RESP_OKAY       = 2'b00;
    localparam logic [1:0]  RESP_SLVERR     = 2'b10;
    localparam int          IRQ_W           = 3;

    typedef enum logic [2:0] {
        PD_DEEP   = 3'b001,
        PD_WAKE   = 3'b010,
        PD_ACTIVE = 3'b100
    } abc_pd_type;

    typedef enum logic [4:0] {
        SQ_IDLE  = 5'b00001,
        SQ_CAL   = 5'b00010,
        SQ_MEAS  = 5'b00100,
        SQ_CALC  = 5'b01000,
        SQ_WRITE = 5'b10000
    } abc_seq_type;
endpackage : abc_pkg

// ==== amp_bias_control_sequencer_test.sv ====
/* Bench: host and device ends joined by the link, software side on AXI4-Lite.
   Assumes abc_pkg; the bench answers converter requests itself. */
`timescale 1ns/1ps
module amp_bias_control_sequencer_test import abc_pkg::*; ;
    logic        clk = 1'b0, rst = 1'b1, ofs = 1'b0, adc_v = 1'b0, awvalid = 1'b0;
    logic        wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, irq, on, req;
    logic [1:0]  bresp, rresp, rr;
    logic [5:0]  ofs_code;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [11:0] temp = 12'h000, dac1, dac2;
    logic [31:0] wdat = 32'h0, rdat, rd;
    logic [47:0] rows [4] = '{48'h04_0123_123_000, 48'h05_0ABC_123_ABC,
                              48'h04_0FFF_FFF_ABC, 48'h05_0000_FFF_000};
    int          n_errors = 0, comparisons = 0, n_req = 0, k, j, base;
    abc_link_if  link ();
    always #2 clk = ~clk;
    // Converter stand-in: answers each request one cycle later
    always @(posedge clk) begin
        adc_v <= req;
        n_req <= n_req + int'(req);
    end
    abc_host abc_host_inst (.I_CLK(clk), .I_RST(rst), .link(link.host), .I_AWADDR(awaddr),
        .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdat), .I_WSTRB(4'hF),
        .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
        .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
        .O_RDATA(rdat), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .O_IRQ(irq));
    abc_device #(.MEAS_PERIOD(20)) abc_device_inst (.I_CLK(clk), .I_RST(rst),
        .link(link.device), .I_OFS_POSITIVE(ofs), .I_ADC_VALID(adc_v), .I_ADC_DATA(temp),
        .I_SENSE_CODE(12'h000), .I_GATE_CODE(12'h000), .O_BLOCKS_ON(on), .O_ADC_REQ(req),
        .O_ADC_CHAN(), .O_DAC1(dac1), .O_DAC2(dac2), .O_OFS_CODE(ofs_code));
    abc_asserts abc_asserts_inst (.I_CLK(clk), .I_RST(rst), .wr_valid(link.wr_valid),
        .wr_ready(link.wr_ready), .addr(link.addr), .wdata(link.wdata),
        .rd_valid(link.rd_valid), .rd_ack(link.rd_ack), .busy(link.busy));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    // One AXI4-Lite transfer; the idle edge at the end keeps valids apart
    task automatic ax(input bit w, input logic [7:0] a, input logic [31:0] d);
        {awaddr, araddr, wdat} <= {a, a, d};
        {awvalid, wvalid, bready, arvalid, rready} <= {w, w, w, !w, !w};
        forever begin
            @(posedge clk);
            {rd, rr} = {rdat, w ? bresp : rresp};
            {awvalid, wvalid, arvalid} <=
                {awvalid && !awready, wvalid && !wready, arvalid && !arready};
            if (w ? bvalid : rvalid) break;
        end
        {bready, rready} <= 2'b00;
        @(posedge clk);
    endtask : ax
    // Link write, then poll until the host reports it sent
    task automatic lw(input logic [7:0] a, input logic [15:0] d);
        ax(1'b1, AX_CMD_WRITE, {8'h00, a, d});
        do ax(1'b0, AX_STATUS, 32'h0); while (rd[0] !== 1'b0);
    endtask : lw
    // Tracking updates take several periods, so wait with a bound
    task automatic wt(input logic [11:0] e1, input logic [11:0] e2);
        for (j = 0; j < 2000 && {dac1, dac2} !== {e1, e2}; j++) @(posedge clk);
        chk(dac1, e1);
        chk(dac2, e2);
    endtask : wt
    task automatic results;
        if (n_errors == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : results
    // Watchdog: the sequence needs a few hundred cycles
    initial begin
        repeat (40000) @(posedge clk);
        n_errors++;
        results();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(on, 0);
        lw(REG_SHUTDOWN, 16'h0000);
        chk(on, 0);
        chk(irq, 0);
        lw(REG_SHUTDOWN, 16'h0002);
        chk(on, 1);
        ax(1'b1, AX_IRQ_MASK, 32'h1);
        chk(irq, 1);
        ax(1'b1, AX_IRQ_STATUS, 32'h7);
        chk(irq, 0);
        for (k = 0; k < 4; k++) begin
            lw(rows[k][47:40], rows[k][39:24]);
            wt(rows[k][23:12], rows[k][11:0]);
        end
        ax(1'b1, AX_CMD_READ, {24'h0, REG_DAC1_RB});
        chk(rr, RESP_OKAY);
        ax(1'b0, AX_RDATA, 32'h0);
        chk(rd, {20'h0, rows[3][23:12]});
        ax(1'b0, 8'h1C, 32'h0);
        chk(rr, RESP_SLVERR);
        chk(rd, 0);
        ofs <= 1'b1;
        lw(REG_CAL_CTRL, 16'h0002);
        for (k = 0; k < 200 && link.busy !== 1'b0; k++) @(posedge clk);
        chk(ofs_code, OFS_MAX);
        ofs <= 1'b0;
        for (k = 1; k < 4; k += 2) begin
            lw(REG_CLK_MODE, 16'(k));
            base = n_req;
            ax(1'b1, AX_CTRL, 32'h1);
            for (j = 0; j < 40 && n_req == base; j++) @(posedge clk);
            chk(n_req != base, 1);
            ax(1'b1, AX_CTRL, 32'h0);
        end
        lw(REG_CLK_MODE, 16'h0000);
        lw(REG_SETPOINT, 16'h0010);
        lw(REG_LUT, 16'h4100);
        lw(REG_LUT, 16'h5300);
        temp <= 12'h100;
        lw(REG_CAL_CTRL, 16'h0007);
        wt(12'h210, 12'h010);
        temp <= 12'h000;
        wt(12'h110, 12'h010);
        results();
    end
endmodule : amp_bias_control_sequencer_test
